/* File: hdl/vmdac_ctrl.sv */
// Top: APB registers, variable fetch and two monitor output channels
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module vmdac_ctrl #(
  parameter int VAR_W   = 32,
  parameter int PU_FRAC = 24
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [11:0]             paddr_i,
  input  wire logic [31:0]             pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  output logic      [13:0]             mon_addr_one_o,
  output logic      [13:0]             mon_addr_two_o,
  input  wire logic [VAR_W-1:0]        mon_data_one_i,
  input  wire logic [VAR_W-1:0]        mon_data_two_i,
  output logic      [vmdac_pkg::DAC_W-1:0] monitor_output_one_o,
  output logic      [vmdac_pkg::DAC_W-1:0] monitor_output_two_o
);
  localparam int VAL_W = VAR_W + 16;
  localparam logic signed [VAR_W-1:0] PU_ONE = VAR_W'(1) <<< PU_FRAC;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  logic        [3:0]                  mult_reg   [2];
  logic        [3:0]                  frac_reg   [2];
  logic                               pol_reg    [2];
  logic        [13:0]                 addr_reg   [2];
  logic signed [VAR_W-1:0]            sample_reg [2];
  logic        [VAR_W-1:0]            mon_data   [2];
  logic        [vmdac_pkg::DAC_W-1:0] code       [2];
  logic                               enum_flag  [2];
  logic        [31:0]                 prdata_reg;

  wire         hit_ch1  = (paddr_i == vmdac_pkg::CH1_ADDR);
  wire         hit_ch2  = (paddr_i == vmdac_pkg::CH2_ADDR);
  wire         hit_stat = (paddr_i == vmdac_pkg::STAT_ADDR);
  wire         hit_any  = hit_ch1 | hit_ch2 | hit_stat;
  wire         setup    = psel_i & ~penable_i;
  wire         access   = psel_i & penable_i;
  // Status register is read only; a write to it is refused
  wire         bad_acc  = ~hit_any | (pwrite_i & hit_stat);
  wire         wr_en    = access & pwrite_i & ~bad_acc;
  wire  [31:0] wmask    = lane_mask(pstrb_i);

  assign mon_data[0] = mon_data_one_i;
  assign mon_data[1] = mon_data_two_i;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      localparam int ML = (c == 0) ? vmdac_pkg::CH1_MULT_LSB : vmdac_pkg::CH2_MULT_LSB;
      localparam int FL = (c == 0) ? vmdac_pkg::CH1_FRAC_LSB : vmdac_pkg::CH2_FRAC_LSB;
      localparam int PB = (c == 0) ? vmdac_pkg::CH1_POL_BIT : vmdac_pkg::CH2_POL_BIT;
      localparam int AW = (c == 0) ? vmdac_pkg::CH1_ADDR_W : vmdac_pkg::CH2_ADDR_W;
      localparam logic [3:0] MRST = (c == 0) ? vmdac_pkg::CH1_MULT_RST
                                             : vmdac_pkg::CH2_MULT_RST;
      logic        [31:0]      img;
      logic        [31:0]      merged;
      logic signed [VAL_W-1:0] value;
      logic                    is_enum;
      wire                     wr = wr_en & ((c == 0) ? hit_ch1 : hit_ch2);

      // Full field image, so partial byte writes keep untouched fields
      assign img = (32'(mult_reg[c]) << ML) | (32'(frac_reg[c]) << FL)
                 | (32'(pol_reg[c]) << PB) | 32'(addr_reg[c]);
      assign merged = (img & ~wmask) | (pwdata_i & wmask);

      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mult_reg[c] <= MRST;
          frac_reg[c] <= vmdac_pkg::FRAC_RST;
          pol_reg[c]  <= vmdac_pkg::VMDAC_BIPOLAR;
          addr_reg[c] <= vmdac_pkg::ADDR_RST;
        end else if (wr) begin
          mult_reg[c] <= merged[ML+:4];
          frac_reg[c] <= merged[FL+:4];
          pol_reg[c]  <= merged[PB];
          addr_reg[c] <= 14'(merged[AW-1:0]);
        end
      end

      // Variable arrives one cycle after its address is presented
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sample_reg[c] <= '0;
        end else begin
          sample_reg[c] <= $signed(mon_data[c]);
        end
      end

      vmdac_scaler #(
        .VAR_W (VAR_W),
        .VAL_W (VAL_W)
      ) u_scaler (
        .sample_i (sample_reg[c]),
        .frac_i   (frac_reg[c]),
        .mult_i   (mult_reg[c]),
        .enum_o   (is_enum),
        .value_o  (value)
      );

      vmdac_mapper #(
        .VAL_W   (VAL_W),
        .PU_FRAC (PU_FRAC)
      ) u_mapper (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .value_i    (value),
        .enum_i     (is_enum),
        .pol_i      (pol_reg[c]),
        .code_o     (code[c]),
        .enum_o     (enum_flag[c])
      );
    end
  endgenerate

  // Write-only scaling and polarity fields read back as zero
  wire [31:0] rd_ch1  = {20'h0_0000, addr_reg[0][vmdac_pkg::CH1_ADDR_W-1:0]};
  wire [31:0] rd_ch2  = {18'h0_0000, addr_reg[1]};
  wire [31:0] rd_stat = (32'(enum_flag[1]) << vmdac_pkg::STAT_ENUM2_BIT)
                      | (32'(enum_flag[0]) << vmdac_pkg::STAT_ENUM1_BIT)
                      | (32'(code[1]) << vmdac_pkg::STAT_CODE2_LSB)
                      | 32'(code[0]);
  wire [31:0] rdata   = hit_ch1 ? rd_ch1 : hit_ch2 ? rd_ch2 : hit_stat ? rd_stat : 32'h0;

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup & ~pwrite_i) begin
      prdata_reg <= rdata;
    end
  end

  assign prdata_o             = prdata_reg;
  assign pready_o             = 1'b1;
  assign pslverr_o            = access & bad_acc;
  assign mon_addr_one_o       = addr_reg[0];
  assign mon_addr_two_o       = addr_reg[1];
  assign monitor_output_one_o = code[0];
  assign monitor_output_two_o = code[1];

  a_enum_mode_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h0) |=> enum_flag[0])
    else $error("enum mode not entered on zero fraction");

  a_mult_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h8 && pol_reg[0] && sample_reg[0] == PU_ONE)
    |=> (code[0] == vmdac_pkg::DAC_MAX && !enum_flag[0]))
    else $error("multiplier affected fractional scaling");

  a_pow2_mult: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h0 && mult_reg[0] == 4'h2 && sample_reg[0] == 3)
    |=> (code[0] == 12'((12 * 4095) / 31)))
    else $error("power of two multiplier wrong");

  a_enum_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h0 && mult_reg[0] == 4'h2 && sample_reg[0] >= 8)
    |=> (code[0] == vmdac_pkg::DAC_MAX))
    else $error("enumeration maximum not at full scale");

  a_frac_half: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h4 && pol_reg[0] && sample_reg[0] == PU_ONE)
    |=> (code[0] == 12'h7ff))
    else $error("fraction four does not give half scale");

  a_unipolar_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] != 4'h0 && pol_reg[0] && sample_reg[0] <= 0) |=> (code[0] == 12'h000))
    else $error("unipolar zero not at bottom");

  a_bipolar_mid: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] != 4'h0 && !pol_reg[0] && sample_reg[0] == 0) |=> (code[0] == 12'h7ff))
    else $error("bipolar zero not at mid scale");

  a_bipolar_floor: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (frac_reg[0] == 4'h8 && !pol_reg[0] && sample_reg[0] == -PU_ONE)
    |=> (code[0] == 12'h000))
    else $error("bipolar minus one not at bottom");

  a_pol_write_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (setup && !pwrite_i && hit_ch1) |=> (prdata_o[31:12] == 20'h0_0000))
    else $error("write-only bits visible on read");

  a_addr_update: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_ch1 && pstrb_i == 4'hf)
    |=> (mon_addr_one_o == {2'b00, $past(pwdata_i[11:0])}))
    else $error("channel one address not updated");

  a_ch2_layout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_ch2 && pstrb_i == 4'hf)
    |=> (frac_reg[1] == $past(pwdata_i[18:15]) && mult_reg[1] == $past(pwdata_i[22:19])
         && pol_reg[1] == $past(pwdata_i[14])))
    else $error("channel two fields misplaced");
endmodule : vmdac_ctrl

/* File: pkg/vmdac_pkg.sv */
// Package: constants for the variable monitor output control block
package vmdac_pkg;
  localparam int          DAC_W      = 12;
  localparam logic [11:0] DAC_MAX    = 12'hfff;
  localparam int          ENUM_MAX   = 31;
  localparam int          FRAC_SHIFT = 3;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  CH1_IDX    = 10'h0f4;
  localparam logic [9:0]  CH2_IDX    = 10'h0f6;
  localparam logic [9:0]  STAT_IDX   = 10'h0f8;
  localparam logic [11:0] CH1_ADDR   = {CH1_IDX, 2'b00};
  localparam logic [11:0] CH2_ADDR   = {CH2_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR  = {STAT_IDX, 2'b00};
  localparam int          CH1_MULT_LSB = 17;
  localparam int          CH1_FRAC_LSB = 13;
  localparam int          CH1_POL_BIT  = 12;
  localparam int          CH1_ADDR_W   = 12;
  localparam int          CH2_MULT_LSB = 19;
  localparam int          CH2_FRAC_LSB = 15;
  localparam int          CH2_POL_BIT  = 14;
  localparam int          CH2_ADDR_W   = 14;
  localparam logic [3:0]  CH1_MULT_RST = 4'h8;
  localparam logic [3:0]  CH2_MULT_RST = 4'h0;
  localparam logic [3:0]  FRAC_RST     = 4'h8;
  localparam logic [13:0] ADDR_RST     = 14'h0000;
  localparam int          STAT_CODE2_LSB = 16;
  localparam int          STAT_ENUM1_BIT = 30;
  localparam int          STAT_ENUM2_BIT = 31;
  typedef enum logic [0:0] {
    VMDAC_BIPOLAR  = 1'b0,
    VMDAC_UNIPOLAR = 1'b1
  } vmdac_pol_t;
endpackage : vmdac_pkg

/* File: hdl/vmdac_scaler.sv */
// Scaler: fractional or power-of-two scaling of one monitored variable
`timescale 1ns/1ps
module vmdac_scaler #(
  parameter int VAR_W = 32,
  parameter int VAL_W = 48
) (
  input  wire logic signed [VAR_W-1:0] sample_i,
  input  wire logic        [3:0]       frac_i,
  input  wire logic        [3:0]       mult_i,
  output logic                         enum_o,
  output logic signed      [VAL_W-1:0] value_o
);
  logic signed [VAR_W+4:0] frac_prod;
  logic signed [VAL_W-1:0] frac_val;
  logic signed [VAL_W-1:0] pow_val;

  assign frac_prod = sample_i * $signed({1'b0, frac_i});
  // Divide by eight, arithmetic so negatives keep their sign
  assign frac_val  = VAL_W'(frac_prod >>> vmdac_pkg::FRAC_SHIFT);
  assign pow_val   = VAL_W'(sample_i) <<< mult_i;
  assign enum_o    = (frac_i == 4'h0);
  assign value_o   = enum_o ? pow_val : frac_val;
endmodule : vmdac_scaler

/* File: hdl/vmdac_mapper.sv */
// Mapper: scaled value to output code, unipolar, bipolar or enumerated
`timescale 1ns/1ps
module vmdac_mapper #(
  parameter int VAL_W   = 48,
  parameter int PU_FRAC = 24
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic signed [VAL_W-1:0]        value_i,
  input  wire logic                           enum_i,
  input  wire logic                           pol_i,
  output logic             [vmdac_pkg::DAC_W-1:0] code_o,
  output logic                                enum_o
);
  localparam int CL_W   = PU_FRAC + 2;
  localparam int PROD_W = CL_W + vmdac_pkg::DAC_W;
  localparam logic signed [VAL_W:0] ONE  = (VAL_W+1)'(1) <<< PU_FRAC;
  localparam logic signed [VAL_W:0] TWO  = ONE <<< 1;
  localparam logic signed [VAL_W:0] EMAX = (VAL_W+1)'(vmdac_pkg::ENUM_MAX);

  logic signed [VAL_W:0]                 v_ext;
  logic signed [VAL_W:0]                 v_bi;
  logic        [CL_W-1:0]                uni_cl;
  logic        [CL_W-1:0]                bi_cl;
  logic        [4:0]                     enum_cl;
  logic        [PROD_W-1:0]              uni_prod;
  logic        [PROD_W-1:0]              bi_prod;
  logic        [PROD_W-1:0]              enum_prod;
  logic        [vmdac_pkg::DAC_W-1:0]    code_next;
  logic        [vmdac_pkg::DAC_W-1:0]    code_reg;
  logic                                  enum_reg;

  assign v_ext = (VAL_W+1)'(value_i);
  assign v_bi  = v_ext + ONE;
  // Out-of-range values saturate at the rails instead of wrapping
  assign uni_cl  = (v_ext < 0) ? '0 : (v_ext > ONE) ? CL_W'(ONE) : CL_W'(v_ext);
  assign bi_cl   = (v_bi < 0) ? '0 : (v_bi > TWO) ? CL_W'(TWO) : CL_W'(v_bi);
  assign enum_cl = (v_ext < 0) ? '0 : (v_ext > EMAX) ? 5'(EMAX) : 5'(v_ext);
  assign uni_prod  = (PROD_W'(uni_cl) * PROD_W'(vmdac_pkg::DAC_MAX)) >> PU_FRAC;
  assign bi_prod   = (PROD_W'(bi_cl) * PROD_W'(vmdac_pkg::DAC_MAX)) >> (PU_FRAC + 1);
  assign enum_prod = (PROD_W'(enum_cl) * PROD_W'(vmdac_pkg::DAC_MAX))
                     / PROD_W'(vmdac_pkg::ENUM_MAX);
  assign code_next = enum_i ? enum_prod[vmdac_pkg::DAC_W-1:0]
                   : (pol_i == vmdac_pkg::VMDAC_UNIPOLAR) ? uni_prod[vmdac_pkg::DAC_W-1:0]
                   : bi_prod[vmdac_pkg::DAC_W-1:0];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg <= '0;
      enum_reg <= 1'b0;
    end else begin
      code_reg <= code_next;
      enum_reg <= enum_i;
    end
  end

  assign code_o = code_reg;
  assign enum_o = enum_reg;
endmodule : vmdac_mapper

/* File: testbench/tb_vmdac_ctrl.sv */
// Testbench: APB configuration and output code checks for both monitor channels
`timescale 1ns/1ps
module tb_vmdac_ctrl;
  logic        core_clk_i;
  logic        rst_n_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [13:0] mon_addr_one_o;
  logic [13:0] mon_addr_two_o;
  logic [31:0] mon_data_one_i;
  logic [31:0] mon_data_two_i;
  logic [11:0] monitor_output_one_o;
  logic [11:0] monitor_output_two_o;
  int          failures;
  int          cmp_count;
  logic [31:0] rd;
  logic        err;
  logic [31:0] w;
  logic [13:0] a;
  // Cases: fraction, multiplier, polarity, variable, expected code
  localparam logic [3:0]  T_FRAC [10] = '{4'h8, 4'h8, 4'h8, 4'h4, 4'hf, 4'h8, 4'h0, 4'h0, 4'h0,
    4'h2};
  localparam logic [3:0]  T_MULT [10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h2, 4'h2, 4'h0,
    4'h0};
  localparam logic        T_POL  [10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
    1'b1};
  localparam logic [31:0] T_VAR  [10] = '{32'h0000_0000, 32'hff00_0000, 32'h0100_0000,
    32'h0100_0000, 32'h0080_0000, 32'h0100_0000, 32'h0000_0003, 32'h0000_000a, 32'h0000_0000,
    32'hff00_0000};
  localparam logic [11:0] T_EXP  [10] = '{12'h7ff, 12'h000, 12'hfff, 12'h7ff, 12'heff,
    12'hfff, 12'h631, 12'hfff, 12'h000, 12'h000};

  vmdac_ctrl dut_u (
    .core_clk_i           (core_clk_i),
    .rst_n_i              (rst_n_i),
    .psel_i               (psel_i),
    .penable_i            (penable_i),
    .pwrite_i             (pwrite_i),
    .paddr_i              (paddr_i),
    .pwdata_i             (pwdata_i),
    .pstrb_i              (pstrb_i),
    .prdata_o             (prdata_o),
    .pready_o             (pready_o),
    .pslverr_o            (pslverr_o),
    .mon_addr_one_o       (mon_addr_one_o),
    .mon_addr_two_o       (mon_addr_two_o),
    .mon_data_one_i       (mon_data_one_i),
    .mon_data_two_i       (mon_data_two_i),
    .monitor_output_one_o (monitor_output_one_o),
    .monitor_output_two_o (monitor_output_two_o)
  );

  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= ad;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: bus transfer never completed", $time);
      stop_test();
    end else begin
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask : apb

  // Reserved bits are set on purpose; they must read back as zero
  function automatic logic [31:0] word(input int ch, input logic [3:0] f, input logic [3:0] m,
                                       input logic p, input logic [13:0] ad);
    if (ch == 0) begin
      return 32'hffe0_0000 | (32'(m) << vmdac_pkg::CH1_MULT_LSB)
        | (32'(f) << vmdac_pkg::CH1_FRAC_LSB) | (32'(p) << vmdac_pkg::CH1_POL_BIT)
        | {20'h0, ad[11:0]};
    end
    return 32'hff80_0000 | (32'(m) << vmdac_pkg::CH2_MULT_LSB)
      | (32'(f) << vmdac_pkg::CH2_FRAC_LSB) | (32'(p) << vmdac_pkg::CH2_POL_BIT)
      | {18'h0, ad};
  endfunction : word

  task automatic idle_codes();
    repeat (4) @(posedge core_clk_i);
    chk({20'h0, monitor_output_one_o}, 32'h7ff, "default code one");
    chk({20'h0, monitor_output_two_o}, 32'h7ff, "default code two");
  endtask : idle_codes

  initial begin
    failures       = 0;
    cmp_count      = 0;
    rst_n_i        = 1'b0;
    psel_i         = 1'b0;
    penable_i      = 1'b0;
    pwrite_i       = 1'b0;
    paddr_i        = 12'h000;
    pwdata_i       = 32'h0000_0000;
    pstrb_i        = 4'hf;
    mon_data_one_i = 32'h0000_0000;
    mon_data_two_i = 32'h0000_0000;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, vmdac_pkg::CH1_ADDR, 32'h0, rd, err);
    chk(rd, 32'h0, "reset read one");
    apb(1'b0, vmdac_pkg::CH2_ADDR, 32'h0, rd, err);
    chk(rd & 32'hff80_3fff, 32'h0, "reset read two");
    chk({18'h0, mon_addr_one_o}, 32'h0, "reset address one");
    idle_codes();
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, vmdac_pkg::STAT_ADDR, 32'hffff_ffff, rd, err);
    chk({31'h0, err}, 32'h1, "status write refused");
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 10; i++) begin
        a = (ch == 0) ? 14'h0fff - 14'(i) : 14'h3fff - 14'(i);
        w = word(ch, T_FRAC[i], T_MULT[i], T_POL[i], a);
        apb(1'b1, (ch == 0) ? vmdac_pkg::CH1_ADDR : vmdac_pkg::CH2_ADDR, w, rd, err);
        chk({31'h0, err}, 32'h0, "config write error");
        if (ch == 0) begin
          mon_data_one_i <= T_VAR[i];
        end else begin
          mon_data_two_i <= T_VAR[i];
        end
        repeat (4) @(posedge core_clk_i);
        chk({20'h0, (ch == 0) ? monitor_output_one_o : monitor_output_two_o}, {20'h0, T_EXP[i]},
            "output code");
        chk({18'h0, (ch == 0) ? mon_addr_one_o : mon_addr_two_o}, {18'h0, a},
            "monitor address");
        apb(1'b0, vmdac_pkg::STAT_ADDR, 32'h0, rd, err);
        chk((ch == 0) ? {rd[30], 19'h0, rd[11:0]} : {rd[31], 19'h0, rd[27:16]},
            {T_FRAC[i] == 4'h0, 19'h0, T_EXP[i]}, "status");
        apb(1'b0, (ch == 0) ? vmdac_pkg::CH1_ADDR : vmdac_pkg::CH2_ADDR, 32'h0, rd, err);
        chk(rd & ((ch == 0) ? 32'hffff_ffff : 32'hff80_3fff), {18'h0, a},
            "read back");
      end
    end
    // Low lane only: address low byte changes, scaling fields must not
    pstrb_i <= 4'h1;
    apb(1'b1, vmdac_pkg::CH1_ADDR, word(0, 4'h1, 4'h0, 1'b0, 14'h00a5), rd, err);
    pstrb_i <= 4'hf;
    repeat (4) @(posedge core_clk_i);
    chk({18'h0, mon_addr_one_o}, 32'h0000_0fa5, "lane merge address");
    chk({20'h0, monitor_output_one_o}, 32'h0, "lane merge keeps scaling");
    // Second reset in mid-run must bring back the default scaling
    @(posedge core_clk_i);
    rst_n_i        <= 1'b0;
    mon_data_one_i <= 32'h0000_0000;
    mon_data_two_i <= 32'h0000_0000;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    idle_codes();
    chk({18'h0, mon_addr_one_o}, 32'h0, "address after second reset");
    stop_test();
  end
endmodule : tb_vmdac_ctrl
